// ### src/psw_flag_logic.v
// Status word flag logic with APB register access
`timescale 1ns/10ps
`include "psw_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Add and subtract set carry on carry out of or borrow into bit 7.
// [RULE2] Multiply and divide always clear carry.
// [RULE3] Decimal adjust sets carry when the decimal sum passes 100; the code sets it when the sum is 100 or more.
// [RULE4] Compare-jump sets carry when first operand is below the second.
// [RULE5] Half-carry follows carry out of or borrow into bit 3.
// [RULE6] Two user flags, bits 5 and 1, change only by software.
// [RULE7] Bank bits pick RAM bank n at bytes 8n to 8n+7.
// [RULE8] Add overflow is carry out of bit 6 xor out of bit 7.
// [RULE9] Subtract overflow is borrow into bit 6 xor into bit 7.
// [RULE10] Multiply sets overflow when the high product byte is nonzero.
// [RULE11] Divide clears overflow, sets it when divisor is zero.
// [RULE12] Parity is the read-only xor of the accumulator bits.
// [RULE13] Carry-only instructions force or compute carry, leave others alone.
// [RULE14] Each arithmetic group updates only its listed flags.
// [RULE15] Instruction update beats software write; parity tracks accumulator.
module psw_flag_logic (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Arithmetic unit
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [7:0] op_a,
  input wire [7:0] op_b,
  input wire [7:0] op_hi,
  input wire op_bit,
  input wire [7:0] acc,
  // Status to the core
  output reg carry_flag,
  output reg [7:0] program_status_word,
  output reg [4:0] bank_base
);

  ////////////////////////////////////////////////////////////////////////////
  // Internal state
  reg [7:0] status_word;
  reg [7:0] soft_word;
  reg [7:0] next_status_word;
  reg next_carry;
  reg next_half;
  reg next_range;
  reg [4:0] next_bank_base;

  ////////////////////////////////////////////////////////////////////////////
  // Flag arithmetic

  // Carry, half-carry and overflow of a + b + cin, packed
  function [2:0] add_flags;
    input [7:0] a;
    input [7:0] b;
    input cin;
    reg [8:0] full;
    reg [4:0] low_nib;
    reg [7:0] low_seven;
    begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low_nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      low_seven = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
      add_flags = {full[8], low_nib[4], low_seven[7] ^ full[8]};
    end
  endfunction

  // Borrow, half-borrow and overflow of a - b - cin, packed
  function [2:0] sub_flags;
    input [7:0] a;
    input [7:0] b;
    input cin;
    reg [8:0] full;
    reg [4:0] low_nib;
    reg [7:0] low_seven;
    begin
      // Wrapped top bit of each slice is the borrow out of it
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      low_nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      low_seven = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, cin};
      sub_flags = {full[8], low_nib[4], low_seven[7] ^ full[8]};
    end
  endfunction

  // Decimal total has left the two-digit range
  function dec_carry;
    input ext;
    input [7:0] total;
    input cin;
    reg [8:0] wide;
    begin
      // A carry already out of the decimal add stays set
      wide = {ext, total};
      dec_carry = (wide >= `PSW_BCD_LIMIT) | cin;
    end
  endfunction

  // Boolean carry instructions
  function bit_carry;
    input [4:0] code;
    input cin;
    input operand;
    begin
      case (code)
        `PSW_OP_CARRY_INV: begin
          bit_carry = ~cin;
        end
        `PSW_OP_CARRY_AND: begin
          bit_carry = cin & operand;
        end
        `PSW_OP_CARRY_AND_INV: begin
          bit_carry = cin & ~operand;
        end
        `PSW_OP_CARRY_OR: begin
          bit_carry = cin | operand;
        end
        `PSW_OP_CARRY_OR_INV: begin
          bit_carry = cin | ~operand;
        end
        `PSW_OP_CARRY_LOAD: begin
          bit_carry = operand;
        end
        default: begin
          bit_carry = cin;
        end
      endcase
    end
  endfunction

  // Base byte of the selected working-register bank
  function [4:0] bank_addr;
    input [1:0] sel;
    begin
      bank_addr = {sel, {`PSW_BANK_SHIFT{1'b0}}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_status = paddr == `PSW_ADDR_STATUS;
  wire hit_acc = paddr == `PSW_ADDR_ACC;
  wire mapped = hit_status | hit_acc;
  // Write lands only on the edge that completes the transfer
  wire wr_status = access & pready & pwrite & hit_status;
  wire rd_status = setup & ~pwrite & hit_status;
  wire rd_acc = setup & ~pwrite & hit_acc;

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode
  wire [4:0] live_op = op_valid ? op_code : `PSW_OP_NONE;
  wire old_carry = status_word[`PSW_BIT_CARRY];
  wire use_carry_in = (live_op == `PSW_OP_ADD_CARRY) & old_carry;
  wire new_parity = ^acc;
  wire [2:0] add_res = add_flags(op_a, op_b, use_carry_in);
  wire [2:0] sub_res = sub_flags(op_a, op_b, old_carry);
  wire dec_res = dec_carry(op_hi[0], op_a, old_carry);
  wire bit_res = bit_carry(live_op, old_carry, op_bit);

  ////////////////////////////////////////////////////////////////////////////
  // Software write
  always @* begin
    soft_word = status_word;
    // Write applies first; an instruction in the same cycle overrides the flags it updates
    if (wr_status) begin
      soft_word = pwdata[7:0]; // [RULE15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carry
  always @* begin
    next_carry = soft_word[`PSW_BIT_CARRY];
    case (live_op)
      `PSW_OP_ADD, `PSW_OP_ADD_CARRY: begin
        next_carry = add_res[`PSW_RES_CARRY]; // [RULE1] [RULE14]
      end
      `PSW_OP_SUB_BORROW: begin
        next_carry = sub_res[`PSW_RES_CARRY]; // [RULE1] [RULE14]
      end
      `PSW_OP_PRODUCT, `PSW_OP_QUOTIENT: begin
        next_carry = 1'b0; // [RULE2] [RULE14]
      end
      `PSW_OP_DEC_ADJ: begin
        next_carry = dec_res; // [RULE3] [RULE14]
      end
      `PSW_OP_CMP_JUMP: begin
        next_carry = op_a < op_b; // [RULE4] [RULE13]
      end
      `PSW_OP_ROT_RIGHT: begin
        next_carry = op_a[0]; // [RULE13]
      end
      `PSW_OP_ROT_LEFT: begin
        next_carry = op_a[7]; // [RULE13]
      end
      `PSW_OP_CARRY_ONE: begin
        next_carry = 1'b1; // [RULE13]
      end
      `PSW_OP_CARRY_ZERO: begin
        next_carry = 1'b0; // [RULE13]
      end
      `PSW_OP_CARRY_INV, `PSW_OP_CARRY_AND, `PSW_OP_CARRY_AND_INV,
      `PSW_OP_CARRY_OR, `PSW_OP_CARRY_OR_INV, `PSW_OP_CARRY_LOAD: begin
        next_carry = bit_res; // [RULE13]
      end
      default: begin
        next_carry = soft_word[`PSW_BIT_CARRY];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-carry
  always @* begin
    next_half = soft_word[`PSW_BIT_HALF];
    case (live_op)
      `PSW_OP_ADD, `PSW_OP_ADD_CARRY: begin
        next_half = add_res[`PSW_RES_HALF]; // [RULE5] [RULE14]
      end
      `PSW_OP_SUB_BORROW: begin
        next_half = sub_res[`PSW_RES_HALF]; // [RULE5] [RULE14]
      end
      default: begin
        // Multiply, divide and carry-only ops keep it
        next_half = soft_word[`PSW_BIT_HALF]; // [RULE13] [RULE14]
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signed overflow
  always @* begin
    next_range = soft_word[`PSW_BIT_RANGE];
    case (live_op)
      `PSW_OP_ADD, `PSW_OP_ADD_CARRY: begin
        next_range = add_res[`PSW_RES_RANGE]; // [RULE8] [RULE14]
      end
      `PSW_OP_SUB_BORROW: begin
        next_range = sub_res[`PSW_RES_RANGE]; // [RULE9] [RULE14]
      end
      `PSW_OP_PRODUCT: begin
        next_range = |op_hi; // [RULE10] [RULE14]
      end
      `PSW_OP_QUOTIENT: begin
        // Quotient and remainder are undefined in this case
        next_range = ~|op_b; // [RULE11] [RULE14]
      end
      default: begin
        next_range = soft_word[`PSW_BIT_RANGE]; // [RULE13]
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word assembly
  always @* begin
    // User flags and bank bits only ever come from software
    next_status_word = soft_word; // [RULE6]
    next_status_word[`PSW_BIT_CARRY] = next_carry;
    next_status_word[`PSW_BIT_HALF] = next_half;
    next_status_word[`PSW_BIT_RANGE] = next_range;
    // Written parity is dropped; it always follows the accumulator
    next_status_word[`PSW_BIT_PARITY] = new_parity; // [RULE12] [RULE15]
    next_bank_base = bank_addr({next_status_word[`PSW_BIT_BANK_HI],
      next_status_word[`PSW_BIT_BANK_LO]}); // [RULE7]
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and core outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word <= `PSW_RESET;
      program_status_word <= `PSW_RESET;
      carry_flag <= 1'b0;
      bank_base <= 5'h00;
    end else begin
      status_word <= next_status_word;
      program_status_word <= next_status_word;
      carry_flag <= next_carry;
      bank_base <= next_bank_base;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  // No wait states: pready and read data follow the setup cycle. Read
  // data show the word as it stands after the setup edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= 32'h00000000;
      if (rd_status) begin
        prdata <= {24'h000000, next_status_word};
      end else if (rd_acc) begin
        prdata <= {24'h000000, acc};
      end
    end
  end

endmodule

// ### src/psw_map.vh
// Register offsets, bit positions and operation codes of the status word
`ifndef PSW_MAP_VH
`define PSW_MAP_VH
`define PSW_ADDR_STATUS 12'hd0
`define PSW_ADDR_ACC 12'hd4
`define PSW_BIT_CARRY 7
`define PSW_BIT_HALF 6
`define PSW_BIT_USER0 5
`define PSW_BIT_BANK_HI 4
`define PSW_BIT_BANK_LO 3
`define PSW_BIT_RANGE 2
`define PSW_BIT_USER1 1
`define PSW_BIT_PARITY 0
`define PSW_RESET 8'h00
`define PSW_BANK_SHIFT 3
`define PSW_BCD_LIMIT 9'h064
`define PSW_RES_CARRY 2
`define PSW_RES_HALF 1
`define PSW_RES_RANGE 0
`define PSW_OP_NONE 5'h00
`define PSW_OP_ADD 5'h01
`define PSW_OP_ADD_CARRY 5'h02
`define PSW_OP_SUB_BORROW 5'h03
`define PSW_OP_PRODUCT 5'h04
`define PSW_OP_QUOTIENT 5'h05
`define PSW_OP_DEC_ADJ 5'h06
`define PSW_OP_ROT_RIGHT 5'h07
`define PSW_OP_ROT_LEFT 5'h08
`define PSW_OP_CARRY_ONE 5'h09
`define PSW_OP_CARRY_ZERO 5'h0a
`define PSW_OP_CARRY_INV 5'h0b
`define PSW_OP_CARRY_AND 5'h0c
`define PSW_OP_CARRY_AND_INV 5'h0d
`define PSW_OP_CARRY_OR 5'h0e
`define PSW_OP_CARRY_OR_INV 5'h0f
`define PSW_OP_CARRY_LOAD 5'h10
`define PSW_OP_CMP_JUMP 5'h11
`endif

// ### tb/psw_flag_checks_assertions.sv
// Flag update checks on the status word outputs
`timescale 1ns/10ps
`include "psw_map.vh"
module psw_flag_checks (
  input wire pclk,
  input wire presetn,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [7:0] op_a,
  input wire [7:0] op_b,
  input wire [7:0] op_hi,
  input wire [7:0] acc,
  input wire carry_flag,
  input wire [7:0] program_status_word
);
  wire [8:0] s = op_a + op_b;
  wire [4:0] n = op_a[3:0] + op_b[3:0];
  wire [7:0] l = op_a[6:0] + op_b[6:0];
  wire ad = op_valid && op_code == `PSW_OP_ADD;
  wire mu = op_valid && op_code == `PSW_OP_PRODUCT;
  wire qu = op_valid && op_code == `PSW_OP_QUOTIENT;
  wire cj = op_valid && op_code == `PSW_OP_CMP_JUMP;
  wire fc = op_valid &&
    op_code inside {`PSW_OP_CARRY_ONE, `PSW_OP_CARRY_ZERO};
  wire bz = op_b == 8'h00;
  wire c8 = s[8];
  wire h4 = n[4];
  wire ov = s[8] ^ l[7];
  wire lt = op_a < op_b;
  wire hz = |op_hi;
  wire par = ^acc;
  wire c0 = op_code[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_add_carry:
    assert property (ad |=> carry_flag == $past(c8)) else $error("add cy");
  a_prod_carry:
    assert property (mu |=> !carry_flag) else $error("mul cy");
  a_cmp_carry:
    assert property (cj |=> carry_flag == $past(lt)) else $error("cmp cy");
  a_half_carry:
    assert property (ad |=> program_status_word[6] == $past(h4))
      else $error("add ac");
  a_add_ovf:
    assert property (ad |=> program_status_word[2] == $past(ov))
      else $error("add ov");
  a_prod_ovf:
    assert property (mu |=> program_status_word[2] == $past(hz))
      else $error("mul ov");
  a_quot_ovf:
    assert property (qu |=> program_status_word[2] == $past(bz))
      else $error("div ov");
  a_quot_carry:
    assert property (qu |=> !carry_flag) else $error("div cy");
  a_parity_live:
    assert property ($past(presetn) |-> program_status_word[0] == $past(par))
      else $error("parity");
  a_force_carry:
    assert property (fc |=> carry_flag == $past(c0)) else $error("set/clr");
endmodule
bind psw_flag_logic psw_flag_checks u_chk (.pclk(pclk), .presetn(presetn),
  .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
  .op_hi(op_hi), .acc(acc), .carry_flag(carry_flag),
  .program_status_word(program_status_word));

// ### tb/psw_core_model.sv
// Arithmetic unit stand-in issuing one flag operation at a time
`timescale 1ns/10ps
module psw_core_model (
  input wire pclk,
  output logic op_valid = 0,
  output logic [4:0] op_code = 0,
  output logic [7:0] op_a = 0,
  output logic [7:0] op_b = 0,
  output logic [7:0] op_hi = 0,
  output logic op_bit = 0,
  output logic [7:0] acc = 0
);
  task automatic issue(input [4:0] c, input [7:0] a, b, h, input bt);
    @(posedge pclk);
    op_valid <= 1;
    op_bit <= bt;
    op_code <= c;
    op_a <= a;
    op_b <= b;
    op_hi <= h;
    acc <= a + b;
    @(posedge pclk);
    op_valid <= 0;
    // The stale op_a is scrambled so nothing relies on it
    op_a <= ~a;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the status word block
`timescale 1ns/10ps
`include "psw_map.vh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, sd = 32'h00004636;
  wire [31:0] prdata;
  wire pready, pslverr, op_valid, op_bit, carry_flag;
  wire [4:0] op_code, bank_base;
  wire [7:0] op_a, op_b, op_hi, acc, program_status_word;
  logic [32:0] q[$];
  logic [7:0] e = 0, r, la = 0;
  int num_errors = 0, n_checks = 0;
  always #50 pclk = ~pclk;
  psw_core_model core (.pclk(pclk), .op_valid(op_valid), .op_code(op_code),
    .op_a(op_a), .op_b(op_b), .op_hi(op_hi), .op_bit(op_bit), .acc(acc));
  psw_flag_logic dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
    .op_hi(op_hi), .op_bit(op_bit), .acc(acc), .carry_flag(carry_flag),
    .program_status_word(program_status_word), .bank_base(bank_base));
  function automatic logic [7:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd[7:0];
  endfunction
  task chk(string nm, logic [32:0] g, x);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input [11:0] a, input [32:0] x);
    q.push_back(x);
    apb(0, a, 0);
  endtask
  task automatic op(input [4:0] c);
    logic [7:0] a, b, h;
    logic bt, cy, hc, ov, ci;
    logic [8:0] s;
    a = rnd();
    b = rnd();
    h = rnd() & {8{sd[9]}};
    bt = sd[11];
    {cy, hc, ov} = {e[7], e[6], e[2]};
    ci = (c != `PSW_OP_ADD) && e[7];
    s = 9'h000;
    case (c)
      `PSW_OP_ADD, `PSW_OP_ADD_CARRY: begin
        s = a + b + ci;
        cy = s[8];
        hc = int'(a[3:0]) + int'(b[3:0]) + ci > 15;
        ov = a[7] == b[7] && s[7] != a[7];
      end
      `PSW_OP_SUB_BORROW: begin
        s = a - b - ci;
        cy = int'(a) < int'(b) + ci;
        hc = int'(a[3:0]) < int'(b[3:0]) + ci;
        ov = a[7] != b[7] && s[7] != a[7];
      end
      `PSW_OP_PRODUCT: {cy, ov} = {1'b0, h != 0};
      `PSW_OP_QUOTIENT: {cy, ov} = {1'b0, b == 0};
      `PSW_OP_DEC_ADJ: cy = e[7] || int'({h[0], a}) >= 100;
      `PSW_OP_CMP_JUMP: cy = a < b;
      `PSW_OP_ROT_RIGHT: cy = a[0];
      `PSW_OP_ROT_LEFT: cy = a[7];
      `PSW_OP_CARRY_ONE: cy = 1;
      `PSW_OP_CARRY_ZERO: cy = 0;
      `PSW_OP_CARRY_INV: cy = !e[7];
      `PSW_OP_CARRY_AND: cy = e[7] & bt;
      `PSW_OP_CARRY_AND_INV: cy = e[7] & !bt;
      `PSW_OP_CARRY_OR: cy = e[7] | bt;
      `PSW_OP_CARRY_OR_INV: cy = e[7] | !bt;
      default: cy = bt;
    endcase
    la = a + b;
    e = {cy, hc, e[5:3], ov, e[1], ^la};
    core.issue(c, a, b, h, bt);
    @(negedge pclk);
    chk("carry", carry_flag, e[7]);
    rd(`PSW_ADDR_STATUS, e);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk("read", {pslverr, prdata}, q.pop_front());
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(`PSW_ADDR_STATUS, 0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      apb(1, `PSW_ADDR_STATUS, {r[7:5], i[1:0], r[2:0]});
      e = {r[7:5], i[1:0], r[2:1], e[0]};
      rd(`PSW_ADDR_STATUS, e);
      chk("bank", bank_base, 8 * i);
    end
    $display("bank test done");
    repeat (200) op(5'(1 + rnd() % 17));
    rd(`PSW_ADDR_ACC, la);
    $display("op test done");
    r = rnd();
    fork
      apb(1, `PSW_ADDR_STATUS, {1'b0, r[6:0]});
      begin
        @(posedge pclk);
        core.issue(`PSW_OP_CARRY_ONE, 0, 0, 0, 0);
      end
    join
    e = {1'b1, r[6:1], 1'b0};
    rd(`PSW_ADDR_STATUS, e);
    apb(1, `PSW_ADDR_ACC, 8'h55);
    rd(`PSW_ADDR_STATUS, e);
    rd(12'h010, {1'b1, 32'h0});
    $display("bus test done");
    end_of_test;
  end
endmodule
